// ===== include/frpc_pkg.sv
package frpc_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL0_OFS = 8'h00;
  localparam logic [7:0] CTRL1_OFS = 8'h04;
  localparam logic [7:0] CMD_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] PROT_OFS = 8'h10;
  localparam logic [7:0] PMODE_OFS = 8'h14;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL0_RDY_BIT = 0;
  localparam int CTRL0_REWR_BIT = 1;
  localparam int CTRL0_LOCKDIS_BIT = 2;
  localparam int CTRL0_PERR_BIT = 6;
  localparam int CTRL0_EERR_BIT = 7;
  localparam int CTRL1_SUB_BIT = 1;
  localparam int CTRL1_LOCKRES_BIT = 6;
  localparam int CTRL1_BLK_LSB = 8;
  localparam int CMD_BLK_LSB = 8;
  localparam int CMD_AREA_LSB = 12;
  localparam int STAT_RDY_BIT = 7;
  localparam int STAT_EERR_BIT = 5;
  localparam int STAT_PERR_BIT = 4;
  localparam int PROT_PAR_OK_BIT = 8;
  localparam int PROT_SER_OK_BIT = 9;
  localparam int PROT_FIELD_LSB = 6;
  // ----------------------------------------------------------------
  // double-write protected bits: rewrite, lock disable, submode
  // ----------------------------------------------------------------
  localparam int DW_N = 3;
  localparam logic [7:0] DW_OFS [DW_N] = '{CTRL0_OFS, CTRL0_OFS, CTRL1_OFS};
  localparam int DW_BIT [DW_N] = '{CTRL0_REWR_BIT, CTRL0_LOCKDIS_BIT, CTRL1_SUB_BIT};
  // ----------------------------------------------------------------
  // commands, areas, protection values
  // ----------------------------------------------------------------
  localparam logic [2:0] OP_READ_ARRAY = 3'h0;
  localparam logic [2:0] OP_PROGRAM = 3'h1;
  localparam logic [2:0] OP_BLOCK_ERASE = 3'h2;
  localparam logic [2:0] OP_ERASE_ALL = 3'h3;
  localparam logic [2:0] OP_LOCK_PROGRAM = 3'h4;
  localparam logic [2:0] OP_READ_LOCK = 3'h5;
  localparam logic [2:0] OP_CLEAR_STATUS = 3'h6;
  localparam logic [2:0] OP_READ_STATUS = 3'h7;
  localparam logic [1:0] AREA_USER = 2'h0;
  localparam logic [1:0] AREA_FONT = 2'h1;
  localparam logic [1:0] AREA_BOOT = 2'h2;
  localparam logic [1:0] PROTECT_OPEN = 2'h3;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [31:0] ERASED_VECTOR = 32'hffff_ffff;
  localparam int ID_BYTES = 7;
  localparam int ID_W = ID_BYTES * 8;
  localparam logic [23:0] ID_ADDR_FIRST = 24'h0fffdf;
  localparam logic [23:0] ID_ADDR_SECOND = 24'h0fffe3;
  localparam logic [1:0] PM_RESET = 2'h0;
  typedef enum logic [1:0] {FRPC_IDLE = 2'b01, FRPC_BUSY = 2'b10} frpc_state_e;
endpackage : frpc_pkg

// ===== include/frpc_dw_if.sv
`timescale 1ns/1ps
interface frpc_dw_if;
  logic wr;
  logic wdata;
  logic other;
  logic gate;
  logic q;
  modport ctrl (output wr, output wdata, output other, output gate, input q);
  modport bitm (input wr, input wdata, input other, input gate, output q);
endinterface : frpc_dw_if

// ===== design/frpc_dbl_write.sv
`timescale 1ns/1ps
module frpc_dbl_write import frpc_pkg::*; (
  input wire logic i_clk,
  input wire logic i_reset,
  frpc_dw_if.bitm b
);
  typedef struct packed {
    logic q;
    logic armed;
  } frpc_dw_s;
  frpc_dw_s s_r;
  frpc_dw_s s_nxt;

  // ----------------------------------------------------------------
  // zero-then-one sequence
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (!b.gate) begin
      // precondition lost: bit and sequence both drop
      s_nxt.q = 1'b0;
      s_nxt.armed = 1'b0;
    end else if (b.wr) begin
      if (!b.wdata) begin
        s_nxt.q = 1'b0;
        s_nxt.armed = 1'b1;
      end else begin
        if (s_r.armed) begin
          s_nxt.q = 1'b1;
        end
        s_nxt.armed = 1'b0;
      end
    end else if (b.other) begin
      s_nxt.armed = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign b.q = s_r.q;

  property p_one_after_zero;
    @(posedge i_clk) disable iff (i_reset)
    $rose(s_r.q) |-> $past(s_r.armed) && $past(b.wr) && $past(b.wdata);
  endproperty
  a_one_after_zero: assert property (p_one_after_zero) else $error("bit set without zero");
  c_bit_set: cover property (@(posedge i_clk) disable iff (i_reset) $rose(s_r.q));
endmodule : frpc_dbl_write

// ===== design/flash_rewrite_protect_ctrl.sv
// Overview of operation
// - parallel access blocked unless protect field 11b
// - erase protect block gives FFh, unprotects
// - serial commands rejected while ID mismatches
// - erased reset vector skips ID check
// - seven ID bytes stored near vector top
// - rewrite only user and font areas
// - ROM submode refuses own-block program/erase
// - ROM submode erase-all refused unless safe
// - ROM submode: no status register read
// - after op: status mode RAM, array ROM
// - ROM submode holds CPU during auto ops
// - control bits report state; RAM status register
// - rewrite enable by zero-then-one write
// - submode select zero-then-one after rewrite enable
// - rewrite mode forces block-A and extension bits
// - ready/busy low during busy commands
// - error flags cleared only by clear-status
// - lock disable ignores locks; erase unlocks
`timescale 1ns/1ps
module flash_rewrite_protect_ctrl import frpc_pkg::*; #(
  parameter int NBLK = 16,
  parameter int BLK_W = $clog2(NBLK)
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [7:0] i_protect_byte,
  input wire logic [31:0] i_reset_vector,
  input wire logic [ID_W-1:0] i_stored_id,
  input wire logic [ID_W-1:0] i_rx_id,
  input wire logic i_rx_id_valid,
  output logic o_parallel_access_ok,
  output logic o_serial_cmd_accept,
  output logic o_flash_start,
  output logic [2:0] o_flash_op,
  output logic [BLK_W-1:0] o_flash_block,
  output logic o_flash_font,
  input wire logic i_flash_done,
  input wire logic i_flash_fail,
  input wire logic i_lock_status,
  output logic o_cpu_hold,
  output logic o_status_read_mode,
  output logic o_block_a_enable,
  output logic o_internal_area_extend,
  output logic o_rewrite_mode,
  output logic o_rom_exec_mode
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    frpc_state_e st;
    logic [2:0] op;
    logic [BLK_W-1:0] blk;
    logic font;
    logic start;
    logic prog_err;
    logic erase_err;
    logic [BLK_W-1:0] ctl_blk;
    logic lock_res;
    logic status_mode;
    logic hold;
    logic [1:0] pm;
    logic [1:0] pm_out;
    logic [NBLK-1:0] locked;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic id_ok;
    logic ser_ok;
    logic par_ok;
  } frpc_main_s;
  frpc_main_s s_r;
  frpc_main_s s_nxt;
  logic setup;
  logic acc;
  logic wr_acc;
  logic mapped;
  logic [31:0] rd;
  logic [DW_N-1:0] dw_q;
  logic [DW_N-1:0] dw_gate;
  logic rewr;
  logic lock_dis;
  logic sub;
  logic cmd_wr;
  logic [2:0] c_op;
  logic [BLK_W-1:0] c_blk;
  logic [1:0] c_area;
  logic c_pe;
  logic refuse;
  logic clr_cmd;
  assign setup = i_psel && !i_penable;
  assign acc = i_psel && i_penable && s_r.pready;
  assign wr_acc = acc && i_pwrite;
  assign rewr = dw_q[0];
  assign lock_dis = dw_q[1];
  assign sub = dw_q[2];
  assign dw_gate = {rewr, rewr, 1'b1};
  // ----------------------------------------------------------------
  // double-write protected control bits
  // ----------------------------------------------------------------
  frpc_dw_if dw [DW_N] ();
  genvar g;
  generate
    for (g = 0; g < DW_N; g++) begin : g_dw
      assign dw[g].wr = wr_acc && (i_paddr == DW_OFS[g]);
      assign dw[g].wdata = i_pwdata[DW_BIT[g]];
      assign dw[g].other = acc && !dw[g].wr;
      assign dw[g].gate = dw_gate[g];
      assign dw_q[g] = dw[g].q;
      frpc_dbl_write u_dw (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .b(dw[g].bitm)
      );
    end
  endgenerate
  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  assign c_op = i_pwdata[2:0];
  assign c_blk = i_pwdata[CMD_BLK_LSB +: BLK_W];
  assign c_area = i_pwdata[CMD_AREA_LSB +: 2];
  assign c_pe = (c_op == OP_PROGRAM) || (c_op == OP_BLOCK_ERASE);
  // commands only in rewrite mode and only while ready
  assign cmd_wr = wr_acc && (i_paddr == CMD_OFS) && rewr && (s_r.st == FRPC_IDLE);
  assign clr_cmd = cmd_wr && (c_op == OP_CLEAR_STATUS);
  always_comb begin
    refuse = 1'b0;
    if (c_area != AREA_USER && c_area != AREA_FONT) refuse = 1'b1;
    if (sub && c_pe && c_area == AREA_USER && c_blk == s_r.ctl_blk) refuse = 1'b1;
    if (sub && c_op == OP_ERASE_ALL && (!s_r.locked[s_r.ctl_blk] || lock_dis)) refuse = 1'b1;
    if (c_pe && c_area == AREA_USER && s_r.locked[c_blk] && !lock_dis) refuse = 1'b1;
  end
  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd = 32'h0;
    mapped = 1'b1;
    unique case (i_paddr)
      CTRL0_OFS: begin
        rd[CTRL0_RDY_BIT] = (s_r.st == FRPC_IDLE);
        rd[CTRL0_REWR_BIT] = rewr;
        rd[CTRL0_LOCKDIS_BIT] = lock_dis;
        rd[CTRL0_PERR_BIT] = s_r.prog_err;
        rd[CTRL0_EERR_BIT] = s_r.erase_err;
      end
      CTRL1_OFS: begin
        rd[CTRL1_SUB_BIT] = sub;
        rd[CTRL1_LOCKRES_BIT] = s_r.lock_res;
        rd[CTRL1_BLK_LSB +: BLK_W] = s_r.ctl_blk;
      end
      CMD_OFS: rd = 32'h0;
      STATUS_OFS: begin
        if (!sub) begin
          rd[STAT_RDY_BIT] = (s_r.st == FRPC_IDLE);
          rd[STAT_EERR_BIT] = s_r.erase_err;
          rd[STAT_PERR_BIT] = s_r.prog_err;
        end
      end
      PROT_OFS: begin
        rd[7:0] = i_protect_byte;
        rd[PROT_PAR_OK_BIT] = s_r.par_ok;
        rd[PROT_SER_OK_BIT] = s_r.ser_ok;
      end
      PMODE_OFS: rd[1:0] = s_r.pm;
      default: mapped = 1'b0;
    endcase
  end
  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.start = 1'b0;
    // zero wait states: ready rises in the access phase only
    s_nxt.pready = setup;
    s_nxt.pslverr = setup && !mapped;
    s_nxt.prdata = (setup && !i_pwrite) ? rd : 32'h0;
    if (wr_acc && i_paddr == CTRL1_OFS) s_nxt.ctl_blk = i_pwdata[CTRL1_BLK_LSB +: BLK_W];
    if (wr_acc && i_paddr == PMODE_OFS) s_nxt.pm = i_pwdata[1:0];
    if (cmd_wr) begin
      unique case (c_op)
        OP_CLEAR_STATUS: begin
          s_nxt.prog_err = 1'b0;
          s_nxt.erase_err = 1'b0;
        end
        OP_READ_STATUS: begin
          if (!sub) s_nxt.status_mode = 1'b1;
        end
        OP_READ_ARRAY: s_nxt.status_mode = 1'b0;
        default: begin
          if (refuse) begin
            if (c_op == OP_PROGRAM || c_op == OP_LOCK_PROGRAM) begin
              s_nxt.prog_err = 1'b1;
            end else if (c_op != OP_READ_LOCK) begin
              s_nxt.erase_err = 1'b1;
            end
          end else begin
            s_nxt.st = FRPC_BUSY;
            s_nxt.op = c_op;
            s_nxt.blk = c_blk;
            s_nxt.font = (c_area == AREA_FONT);
            s_nxt.start = 1'b1;
          end
        end
      endcase
    end
    unique case (s_r.st)
      FRPC_IDLE: ;
      FRPC_BUSY: begin
        if (i_flash_done) begin
          s_nxt.st = FRPC_IDLE;
          s_nxt.status_mode = !sub;
          if (i_flash_fail) begin
            if (s_r.op == OP_PROGRAM || s_r.op == OP_LOCK_PROGRAM) begin
              s_nxt.prog_err = 1'b1;
            end else if (s_r.op != OP_READ_LOCK) begin
              s_nxt.erase_err = 1'b1;
            end
          end else begin
            if (s_r.op == OP_BLOCK_ERASE && lock_dis && !s_r.font) s_nxt.locked[s_r.blk] = 1'b0;
            if (s_r.op == OP_ERASE_ALL && lock_dis) s_nxt.locked = '0;
            if (s_r.op == OP_LOCK_PROGRAM && !s_r.font) s_nxt.locked[s_r.blk] = 1'b1;
          end
          if (s_r.op == OP_READ_LOCK) s_nxt.lock_res = i_lock_status;
        end
      end
      default: s_nxt.st = FRPC_IDLE;
    endcase
    s_nxt.hold = (s_nxt.st == FRPC_BUSY) && sub;
    // forced while rewriting; stored value returns after
    s_nxt.pm_out = s_nxt.pm | {2{rewr}};
    if (i_rx_id_valid) s_nxt.id_ok = (i_rx_id == i_stored_id);
    s_nxt.ser_ok = (i_reset_vector == ERASED_VECTOR) || s_nxt.id_ok;
    s_nxt.par_ok = (i_protect_byte[PROT_FIELD_LSB +: 2] == PROTECT_OPEN);
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s_r <= '0;
      s_r.st <= FRPC_IDLE;
      s_r.pm <= PM_RESET;
      s_r.pm_out <= PM_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_prdata = s_r.prdata;
  assign o_pready = s_r.pready;
  assign o_pslverr = s_r.pslverr;
  assign o_parallel_access_ok = s_r.par_ok;
  assign o_serial_cmd_accept = s_r.ser_ok;
  assign o_flash_start = s_r.start;
  assign o_flash_op = s_r.op;
  assign o_flash_block = s_r.blk;
  assign o_flash_font = s_r.font;
  assign o_cpu_hold = s_r.hold;
  assign o_status_read_mode = s_r.status_mode;
  assign o_block_a_enable = s_r.pm_out[0];
  assign o_internal_area_extend = s_r.pm_out[1];
  assign o_rewrite_mode = rewr;
  assign o_rom_exec_mode = sub;
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  property p_par_block;
    i_protect_byte[PROT_FIELD_LSB +: 2] != PROTECT_OPEN |=> !o_parallel_access_ok;
  endproperty
  a_par_block: assert property (p_par_block) else $error("parallel access not blocked");
  property p_erased_open;
    i_protect_byte == ERASED_BYTE |=> o_parallel_access_ok;
  endproperty
  a_erased_open: assert property (p_erased_open) else $error("erased byte not open");
  property p_id_reject;
    i_rx_id_valid && i_rx_id != i_stored_id && i_reset_vector != ERASED_VECTOR
      |=> !o_serial_cmd_accept;
  endproperty
  a_id_reject: assert property (p_id_reject) else $error("mismatched ID accepted");
  property p_blank_accept;
    i_reset_vector == ERASED_VECTOR |=> o_serial_cmd_accept;
  endproperty
  a_blank_accept: assert property (p_blank_accept) else $error("blank vector not accepted");
  property p_boot_refused;
    cmd_wr && c_area == AREA_BOOT |=> !o_flash_start;
  endproperty
  a_boot_refused: assert property (p_boot_refused) else $error("boot area started");
  property p_own_block;
    o_flash_start && sub && !o_flash_font
      && (o_flash_op == OP_PROGRAM || o_flash_op == OP_BLOCK_ERASE)
      |-> o_flash_block != s_r.ctl_blk;
  endproperty
  a_own_block: assert property (p_own_block) else $error("own block rewritten");
  property p_erase_all_guard;
    o_flash_start && sub && o_flash_op == OP_ERASE_ALL |-> !lock_dis && s_r.locked[s_r.ctl_blk];
  endproperty
  a_erase_all_guard: assert property (p_erase_all_guard) else $error("erase all unsafe");
  property p_status_hidden;
    setup && !i_pwrite && i_paddr == STATUS_OFS && sub |=> o_prdata == 32'h0;
  endproperty
  a_status_hidden: assert property (p_status_hidden) else $error("status readable");
  property p_mode_after;
    s_r.st == FRPC_BUSY && i_flash_done |=> o_status_read_mode == !$past(sub);
  endproperty
  a_mode_after: assert property (p_mode_after) else $error("wrong mode after op");
  property p_hold;
    o_flash_start && sub |-> o_cpu_hold && s_r.st == FRPC_BUSY;
  endproperty
  a_hold: assert property (p_hold) else $error("cpu not held");
  property p_busy_read;
    setup && !i_pwrite && i_paddr == CTRL0_OFS && s_r.st == FRPC_BUSY |=> !o_prdata[0];
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("ready during busy");
  property p_err_sticky;
    s_r.prog_err && !clr_cmd |=> s_r.prog_err;
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("error cleared early");
  property p_pm_forced;
    rewr |=> o_block_a_enable && o_internal_area_extend;
  endproperty
  a_pm_forced: assert property (p_pm_forced) else $error("mode bits not forced");

  c_rom_op: cover property (o_flash_start && sub);
  c_ram_done: cover property (s_r.st == FRPC_BUSY && i_flash_done && !sub);
  c_refused: cover property (cmd_wr && refuse);
  c_id_ok: cover property (i_rx_id_valid ##1 o_serial_cmd_accept);
endmodule : flash_rewrite_protect_ctrl

// ===== testbench/frpc_flash_model.sv
`timescale 1ns/1ps
module frpc_flash_model import frpc_pkg::*; (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_start,
  input wire logic [2:0] i_op,
  input wire logic [3:0] i_block,
  input wire logic i_slow,
  input wire logic i_fail,
  input wire logic i_prot_wr,
  input wire logic [7:0] i_prot_val,
  output logic o_done,
  output logic o_fail,
  output logic o_lock,
  output logic [7:0] o_protect
);
  // ----------------------------------------
  // array timing and protect byte
  // ----------------------------------------
  localparam logic [3:0] PROT_BLK = 4'hf;
  int cnt;
  logic last_fail = 1'b0;
  always @(posedge i_clk) begin
    o_done <= 1'b0;
    if (i_prot_wr) o_protect <= i_prot_val;
    if (i_reset) cnt <= 0;
    else if (i_start) cnt <= i_slow ? 9 : 1;
    else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        o_done <= 1'b1;
        last_fail <= i_fail;
        if (i_op == OP_BLOCK_ERASE && i_block == PROT_BLK && !i_fail) o_protect <= ERASED_BYTE;
      end
    end
  end
  // qualifiers are only meaningful with done, so they wander otherwise
  assign o_fail = o_done ? last_fail : ~last_fail;
  assign o_lock = o_done | cnt[0];
endmodule : frpc_flash_model

// ===== testbench/tb_flash_rewrite_protect_ctrl.sv
`timescale 1ns/1ps
module tb_flash_rewrite_protect_ctrl import frpc_pkg::*;;
  logic clk, rst, psel, pen, pwr, rxv, slow, fail, pw, pready, pslverr, par_ok, ser_ok, err;
  logic [7:0] paddr, pval, prot;
  logic [31:0] pwdata, prdata, vec, rd;
  logic [55:0] sid, rxid;
  logic fstart, ffont, fdone, ffail, flock, hold, srm, bae, iae, rwm, rom;
  logic [2:0] fop;
  logic [3:0] fblk;
  int bad_count = 0, num_checks = 0, starts = 0, cyc = 0;
  flash_rewrite_protect_ctrl i_dut (.i_clk(clk), .i_reset(rst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_protect_byte(prot), .i_reset_vector(vec),
    .i_stored_id(sid), .i_rx_id(rxid), .i_rx_id_valid(rxv), .o_parallel_access_ok(par_ok),
    .o_serial_cmd_accept(ser_ok), .o_flash_start(fstart), .o_flash_op(fop),
    .o_flash_block(fblk), .o_flash_font(ffont), .i_flash_done(fdone), .i_flash_fail(ffail),
    .i_lock_status(flock), .o_cpu_hold(hold), .o_status_read_mode(srm),
    .o_block_a_enable(bae), .o_internal_area_extend(iae), .o_rewrite_mode(rwm),
    .o_rom_exec_mode(rom));
  frpc_flash_model i_flash (.i_clk(clk), .i_reset(rst), .i_start(fstart), .i_op(fop),
    .i_block(fblk), .i_slow(slow), .i_fail(fail), .i_prot_wr(pw), .i_prot_val(pval),
    .o_done(fdone), .o_fail(ffail), .o_lock(flock), .o_protect(prot));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (fstart === 1'b1) starts <= starts + 1;
    if (cyc == 5000) begin
      bad_count++;
      results();
    end
  end
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // only the global timeout ends a stuck wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdchk
  task automatic issue(input logic [2:0] op, input logic [3:0] b, input logic [1:0] ar,
      input int ns);
    int s;
    s = starts;
    apb(1'b1, CMD_OFS, {18'h0, ar, b, 5'h0, op});
    @(posedge clk);
    chk(starts - s, ns);
  endtask : issue
  task automatic settle;
    while (fdone !== 1'b1) begin
      @(posedge clk);
    end
    repeat (2) @(posedge clk);
  endtask : settle
  task automatic idsend(input logic [55:0] id);
    rxid <= id;
    rxv <= 1'b1;
    @(posedge clk);
    rxv <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : idsend
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rst, pw} <= 2'b11;
    {psel, pen, pwr, rxv, slow, fail} <= 6'h0;
    {paddr, pwdata, rxid} <= '0;
    // protecting value keeps low six bits set
    pval <= 8'h3f;
    vec <= 32'h0000_1234;
    sid <= 56'h11_2233_4455_6677;
    repeat (12) @(posedge clk);
    {rst, pw} <= 2'b00;
    @(posedge clk);
    rdchk(CTRL0_OFS, 32'h1);
    rdchk(PROT_OFS, 32'h3f);
    apb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    chk(err, 1'b1);
    idsend(56'h0);
    chk(ser_ok, 1'b0);
    // seven stored bytes, first byte first
    idsend(sid);
    chk(ser_ok, 1'b1);
    vec <= ERASED_VECTOR;
    idsend(56'h0);
    chk(ser_ok, 1'b1);
    apb(1'b1, CTRL0_OFS, 32'h2);
    rdchk(CTRL0_OFS, 32'h1);
    apb(1'b1, CTRL0_OFS, 32'h0);
    apb(1'b1, CTRL0_OFS, 32'h2);
    rdchk(CTRL0_OFS, 32'h3);
    chk({rwm, rom, bae, iae}, 4'hb);
    slow <= 1'b1;
    issue(OP_PROGRAM, 4'h2, AREA_USER, 1);
    chk({fop, fblk, hold}, {OP_PROGRAM, 4'h2, 1'b0});
    rdchk(CTRL0_OFS, 32'h2);
    settle();
    chk(srm, 1'b1);
    rdchk(STATUS_OFS, 32'h80);
    slow <= 1'b0;
    fail <= 1'b1;
    issue(OP_BLOCK_ERASE, 4'h1, AREA_FONT, 1);
    chk(ffont, 1'b1);
    settle();
    fail <= 1'b0;
    rdchk(STATUS_OFS, 32'ha0);
    issue(OP_PROGRAM, 4'h0, AREA_BOOT, 0);
    rdchk(CTRL0_OFS, 32'hc3);
    apb(1'b1, CMD_OFS, {29'h0, OP_CLEAR_STATUS});
    rdchk(CTRL0_OFS, 32'h3);
    issue(OP_BLOCK_ERASE, 4'hf, AREA_USER, 1);
    settle();
    rdchk(PROT_OFS, 32'h3ff);
    chk(par_ok, 1'b1);
    // lock block 6, then refuse, unlock by erase with locks disabled
    issue(OP_LOCK_PROGRAM, 4'h6, AREA_USER, 1);
    settle();
    issue(OP_READ_LOCK, 4'h6, AREA_USER, 1);
    settle();
    rdchk(CTRL1_OFS, 32'h40);
    issue(OP_PROGRAM, 4'h6, AREA_USER, 0);
    apb(1'b1, CMD_OFS, {29'h0, OP_CLEAR_STATUS});
    apb(1'b1, CTRL0_OFS, 32'h2);
    apb(1'b1, CTRL0_OFS, 32'h6);
    rdchk(CTRL0_OFS, 32'h7);
    issue(OP_BLOCK_ERASE, 4'h6, AREA_USER, 1);
    settle();
    apb(1'b1, CTRL0_OFS, 32'h2);
    issue(OP_PROGRAM, 4'h6, AREA_USER, 1);
    settle();
    apb(1'b1, CMD_OFS, {29'h0, OP_READ_ARRAY});
    chk(srm, 1'b0);
    apb(1'b1, CMD_OFS, {29'h0, OP_READ_STATUS});
    chk(srm, 1'b1);
    // control program sits in block 3
    apb(1'b1, CTRL1_OFS, 32'h300);
    apb(1'b1, CTRL1_OFS, 32'h302);
    chk(rom, 1'b1);
    slow <= 1'b1;
    issue(OP_PROGRAM, 4'h3, AREA_USER, 0);
    rdchk(CTRL0_OFS, 32'h43);
    issue(OP_ERASE_ALL, 4'h0, AREA_USER, 0);
    rdchk(CTRL0_OFS, 32'hc3);
    apb(1'b1, CMD_OFS, {29'h0, OP_CLEAR_STATUS});
    issue(OP_PROGRAM, 4'h5, AREA_USER, 1);
    chk(hold, 1'b1);
    settle();
    chk({hold, srm}, 2'b00);
    apb(1'b1, CMD_OFS, {29'h0, OP_READ_STATUS});
    chk(srm, 1'b0);
    rdchk(STATUS_OFS, 32'h0);
    apb(1'b1, CTRL0_OFS, 32'h0);
    @(posedge clk);
    chk({rwm, rom, bae, iae}, 4'h0);
    results();
  end
endmodule : tb_flash_rewrite_protect_ctrl
